// file: inc/uia_map.svh
// Purpose: offsets, field positions and reset values of the usb irq block
// Assumes: 32-bit ahb-lite register words, byte addresses below
// Notes: definitions only
`ifndef UIA_MAP_SVH
`define UIA_MAP_SVH

// register word offsets (byte addresses)
`define UIA_OFF_IRQ 8'h00
`define UIA_OFF_IE 8'h04
`define UIA_OFF_MAIN 8'h08
`define UIA_OFF_EN 8'h0c
`define UIA_OFF_SETUP 8'h10
`define UIA_OFF_AVEC 8'h14
`define UIA_OFF_PWR 8'h18
`define UIA_OFF_SDAT 8'h20
`define UIA_OFF_SDAT_END 8'h3c

// field positions
`define UIA_MAIN_REQ_BIT 4
`define UIA_MAIN_EN_BIT 0
`define UIA_AV_EN_BIT 0
`define UIA_PWR_RESUME_BIT 0
`define UIA_PWR_IDLE_REQ_BIT 1
`define UIA_PWR_IDLE_BIT 2

// source slots by priority index
`define UIA_SLOT_SETUP_DATA 0
`define UIA_SLOT_SETUP_TOKEN 2
`define UIA_NUM_SLOTS 32
`define UIA_RSV_MASK 32'h0e02_0080
`define UIA_HS_MASK 32'h00fc_0020

// autovector layout, fetch substitution and setup completion
`define UIA_AVEC_SHIFT 2
`define UIA_AVEC_ADDR 16'h0045
`define UIA_SETUP_LAST 3'h7
`define UIA_SETUP_ALL 8'hff

// reset values
`define UIA_RST_WORD 32'h0000_0000
`define UIA_RST_BYTE 8'h00

`endif

// file: inc/uia_pkg.sv
// Purpose: shared types of the usb irq aggregator
// Assumes: constants come from uia_map.svh
// Notes: types only
package uia_pkg;

  // one setup byte from the control endpoint receiver
  typedef struct packed {
    logic we;
    logic [2:0] idx;
    logic [7:0] data;
    logic err;
  } uia_setup_wr_t;

  // program fetch from the core
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] rom_byte;
  } uia_fetch_t;

  typedef enum logic {
    UIA_PWR_RUN,
    UIA_PWR_IDLE
  } uia_pwr_t;

endpackage

// file: core/uia_setup_mem.sv
// Purpose: eight setup byte registers with a registered read port
// Assumes: one writer, one reader, same clock
// Notes: read data appear one edge after the address
`timescale 1ns/1ns
`default_nettype none
module uia_setup_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata_q
);
  logic [7:0] mem_q [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem_q[raddr];
    end
  end
endmodule
`default_nettype wire

// file: core/uia_top.sv
// Purpose: usb interrupt aggregator with autovector and resume wake
// Assumes: event inputs are one-cycle pulses on clk_sys
// Notes: registers over ahb-lite; wake inputs are asynchronous pins
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "uia_map.svh"
module uia_top #(
  parameter bit FS_ONLY = 1'b0,
  parameter int NWAKE = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [31:0] usb_events,
  input wire logic setup_token_seen,
  input wire uia_pkg::uia_setup_wr_t setup_wr,
  input wire logic [NWAKE-1:0] wake_pins,
  input wire logic bus_activity,
  input wire uia_pkg::uia_fetch_t fetch,
  output logic [7:0] fetch_byte_q,
  output logic usb_int_q,
  output logic usb_int_pulse_q,
  output logic resume_irq_q,
  output logic osc_run_q
);
  import uia_pkg::*;

  localparam logic [31:0] SLOT_MASK =
    ~`UIA_RSV_MASK & (FS_ONLY ? ~`UIA_HS_MASK : 32'hffff_ffff);

  // lowest set index is the highest priority
  function automatic logic [4:0] top_index(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h1f;
    for (int i = `UIA_NUM_SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] vec_of(input logic [4:0] idx);
    return {1'b0, idx, 2'b00};
  endfunction

  // ---------------- ahb-lite slave ----------------
  logic [7:0] addr_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic [31:0] rd_word;
  logic [7:0] sdat_rdata_q;

  wire take = hsel & htrans[1] & hready;
  wire take_rd = take & ~hwrite;
  wire take_wr = take & hwrite;
  wire wr_irq = wr_pend_q & (addr_q == `UIA_OFF_IRQ);
  wire wr_ie = wr_pend_q & (addr_q == `UIA_OFF_IE);
  wire wr_main = wr_pend_q & (addr_q == `UIA_OFF_MAIN);
  wire wr_en = wr_pend_q & (addr_q == `UIA_OFF_EN);
  wire wr_setup = wr_pend_q & (addr_q == `UIA_OFF_SETUP);
  wire wr_pwr = wr_pend_q & (addr_q == `UIA_OFF_PWR);
  wire rd_sdat = (addr_q >= `UIA_OFF_SDAT) && (addr_q <= `UIA_OFF_SDAT_END);
  wire [2:0] sdat_raddr = haddr[4:2];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr_q <= `UIA_RST_BYTE;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      if (take) begin
        addr_q <= {haddr[7:2], 2'b00};
      end
      wr_pend_q <= take_wr;
      rd_pend_q <= take_rd;
    end
  end

  // one wait state on reads so setup bytes come from a register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hreadyout_q <= 1'b1;
      hrdata_q <= `UIA_RST_WORD;
    end else begin
      hreadyout_q <= ~take_rd;
      if (rd_pend_q) begin
        hrdata_q <= rd_word;
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;

  // ---------------- source latches ----------------
  logic [31:0] irq_q;
  logic [31:0] ie_q;
  logic main_req_q;
  logic main_en_q;
  logic av_en_q;
  logic [7:0] avec_q;
  logic any_q;
  logic clr_hit_q;
  logic [7:0] seen_q;
  logic seen_err_q;

  wire last_byte = setup_wr.we & (setup_wr.idx == `UIA_SETUP_LAST);
  wire [7:0] seen_now = seen_q | (8'h01 << setup_wr.idx);
  wire setup_done = last_byte & ~seen_err_q & ~setup_wr.err &
    (seen_now == `UIA_SETUP_ALL);

  logic [31:0] set_vec;
  always_comb begin
    set_vec = usb_events;
    set_vec[`UIA_SLOT_SETUP_DATA] = setup_done;
    set_vec[`UIA_SLOT_SETUP_TOKEN] = setup_token_seen;
  end

  wire [31:0] set_ok = set_vec & SLOT_MASK;
  wire [31:0] clr_vec = wr_irq ? hwdata : 32'h0;
  // set wins over a clear in the same cycle
  wire [31:0] irq_d = (irq_q & ~clr_vec) | set_ok;
  wire [31:0] gated = irq_q & ie_q;
  wire any_gated = |gated;
  wire clr_hit = |(irq_q & clr_vec & ~set_ok);
  // rising pending, or a latch cleared while others wait
  wire main_pulse = (any_gated & ~any_q) | (clr_hit_q & any_gated);
  wire main_clr = wr_main & ~hwdata[`UIA_MAIN_REQ_BIT];
  wire main_req_d = main_pulse | (main_req_q & ~main_clr);
  wire int_level_d = main_req_d & main_en_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_q <= `UIA_RST_WORD;
      ie_q <= `UIA_RST_WORD;
    end else begin
      irq_q <= irq_d;
      if (wr_ie) begin
        ie_q <= hwdata & SLOT_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      main_req_q <= 1'b0;
      main_en_q <= 1'b0;
      av_en_q <= 1'b0;
      any_q <= 1'b0;
      clr_hit_q <= 1'b0;
    end else begin
      main_req_q <= main_req_d;
      any_q <= any_gated;
      clr_hit_q <= clr_hit;
      if (wr_en) begin
        main_en_q <= hwdata[`UIA_MAIN_EN_BIT];
      end
      if (wr_setup) begin
        av_en_q <= hwdata[`UIA_AV_EN_BIT];
      end
    end
  end

  // core samples edges only; an uncleared main bit swallows re-pulses
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      usb_int_q <= 1'b0;
      usb_int_pulse_q <= 1'b0;
    end else begin
      usb_int_q <= int_level_d;
      usb_int_pulse_q <= int_level_d & ~usb_int_q;
    end
  end

  // ---------------- autovector and fetch ----------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avec_q <= `UIA_RST_BYTE;
    end else if (any_gated) begin
      avec_q <= vec_of(top_index(gated));
    end
  end

  wire subst = av_en_q & (fetch.addr == `UIA_AVEC_ADDR);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fetch_byte_q <= `UIA_RST_BYTE;
    end else begin
      fetch_byte_q <= subst ? avec_q : fetch.rom_byte;
    end
  end

  // ---------------- setup bytes ----------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      seen_q <= `UIA_RST_BYTE;
      seen_err_q <= 1'b0;
    end else if (setup_token_seen) begin
      seen_q <= `UIA_RST_BYTE;
      seen_err_q <= 1'b0;
    end else if (setup_wr.we) begin
      seen_q <= last_byte ? `UIA_RST_BYTE : seen_now;
      seen_err_q <= last_byte ? 1'b0 : (seen_err_q | setup_wr.err);
    end
  end

  uia_setup_mem #(
    .DEPTH(8),
    .AW(3)
  ) u_sdat (
    .clk_sys(clk_sys),
    .reset(reset),
    .we(setup_wr.we),
    .waddr(setup_wr.idx),
    .wdata(setup_wr.data),
    .raddr(sdat_raddr),
    .rdata_q(sdat_rdata_q)
  );

  // ---------------- resume and idle ----------------
  logic [NWAKE:0] wake_s1_q;
  logic [NWAKE:0] wake_s2_q;
  uia_pwr_t pwr_q;
  uia_pwr_t pwr_d;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wake_s1_q <= '0;
      wake_s2_q <= '0;
    end else begin
      wake_s1_q <= {bus_activity, wake_pins};
      wake_s2_q <= wake_s1_q;
    end
  end

  wire wake = |wake_s2_q;
  wire idle_req = wr_pwr & hwdata[`UIA_PWR_IDLE_REQ_BIT];
  wire resume_clr = wr_pwr & hwdata[`UIA_PWR_RESUME_BIT];
  wire resume_set = (pwr_q == UIA_PWR_IDLE) & wake;

  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      UIA_PWR_RUN: begin
        if (idle_req) begin
          pwr_d = UIA_PWR_IDLE;
        end
      end
      UIA_PWR_IDLE: begin
        if (wake) begin
          pwr_d = UIA_PWR_RUN;
        end
      end
      default: pwr_d = UIA_PWR_RUN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pwr_q <= UIA_PWR_RUN;
      osc_run_q <= 1'b1;
      resume_irq_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      osc_run_q <= (pwr_d == UIA_PWR_RUN);
      resume_irq_q <= resume_set | (resume_irq_q & ~resume_clr);
    end
  end

  // ---------------- read mux ----------------
  always_comb begin
    rd_word = `UIA_RST_WORD;
    if (rd_sdat) begin
      rd_word = {24'h0, sdat_rdata_q};
    end else begin
      case (addr_q)
        `UIA_OFF_IRQ: rd_word = irq_q;
        `UIA_OFF_IE: rd_word = ie_q;
        `UIA_OFF_MAIN: rd_word[`UIA_MAIN_REQ_BIT] = main_req_q;
        `UIA_OFF_EN: rd_word[`UIA_MAIN_EN_BIT] = main_en_q;
        `UIA_OFF_SETUP: rd_word[`UIA_AV_EN_BIT] = av_en_q;
        `UIA_OFF_AVEC: rd_word[7:0] = avec_q;
        `UIA_OFF_PWR: begin
          rd_word[`UIA_PWR_RESUME_BIT] = resume_irq_q;
          rd_word[`UIA_PWR_IDLE_BIT] = (pwr_q == UIA_PWR_IDLE);
        end
        default: rd_word = `UIA_RST_WORD;
      endcase
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_latch_clear_one: assert property (
    (wr_irq && irq_q[9] && hwdata[9] && !set_ok[9]) |=> !irq_q[9])
    else $error("source latch not cleared by a one");
  a_latch_write_zero: assert property (
    (wr_irq && irq_q[1] && !hwdata[1]) |=> irq_q[1])
    else $error("source latch lost on a zero write");
  a_reserved_idle: assert property (
    (irq_q & ~SLOT_MASK) == 32'h0)
    else $error("reserved slot latched");
  a_vec_order: assert property (
    (gated[4] && gated[12]) |=> (avec_q < 8'h30))
    else $error("lower priority vector shown first");
  a_vec_align: assert property (
    avec_q[1:0] == 2'b00 && !avec_q[7])
    else $error("autovector not aligned");
  a_vec_hold: assert property (
    !any_gated |=> $stable(avec_q))
    else $error("autovector changed with nothing pending");
  a_main_set: assert property (
    (any_gated && !any_q) |=> main_req_q)
    else $error("main request not set by new source");
  a_main_clear: assert property (
    (main_clr && !main_pulse) |=> !main_req_q)
    else $error("main request not cleared by zero");
  a_repulse: assert property (
    (clr_hit && !main_req_d && |(gated & ~clr_vec))
      |=> ##1 main_req_q)
    else $error("no re-pulse after latch clear");
  a_int_edge: assert property (
    usb_int_pulse_q |=> !usb_int_pulse_q)
    else $error("main interrupt pulse longer than one cycle");
  a_fetch_subst: assert property (
    (av_en_q && fetch.addr == `UIA_AVEC_ADDR)
      |=> fetch_byte_q == $past(avec_q))
    else $error("autovector not substituted");
  a_wake_resume: assert property (
    (pwr_q == UIA_PWR_IDLE && wake) |=> (osc_run_q && resume_irq_q))
    else $error("no resume after wake in idle");

  c_repulse: cover property (clr_hit_q && any_gated && main_pulse);
  c_subst: cover property (subst && avec_q != 8'h00);
  c_setup_done: cover property (setup_done);
  c_wake: cover property (resume_set);
endmodule
`default_nettype wire

// file: test/uia_core_model.sv
// Purpose: core-side model: program rom and usb interrupt edge counter
// Assumes: rom byte is the inverse of the fetch address low byte
// Notes: only rises are counted, as an edge-triggered core sees them
`timescale 1ns/1ns
`default_nettype none
module uia_core_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic usb_int_pulse_q,
  input wire logic [15:0] pc,
  output var uia_pkg::uia_fetch_t fetch,
  output logic [15:0] edge_count
);
  import uia_pkg::*;
  logic prev_q;
  // rom differs from every vector byte so a substitution is visible
  assign fetch = '{addr: pc, rom_byte: ~pc[7:0]};
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prev_q <= 1'b0;
      edge_count <= 16'h0;
    end else begin
      prev_q <= usb_int_pulse_q;
      if (usb_int_pulse_q && !prev_q) begin
        edge_count <= edge_count + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: test/tb_usb_interrupt_aggregator.sv
// Purpose: self-checking bench of the usb interrupt aggregator
// Assumes: single ahb-lite master, one clock, events as 1-cycle pulses
// Notes: firmware order (main bit before latch) is kept by the tasks
`timescale 1ns/1ns
`default_nettype none
`include "uia_map.svh"
module tb_usb_interrupt_aggregator;
  import uia_pkg::*;
  localparam logic [31:0] r_irq = {24'h0, `UIA_OFF_IRQ};
  localparam logic [31:0] r_ie = {24'h0, `UIA_OFF_IE};
  localparam logic [31:0] r_main = {24'h0, `UIA_OFF_MAIN};
  localparam logic [31:0] r_en = {24'h0, `UIA_OFF_EN};
  localparam logic [31:0] r_av = {24'h0, `UIA_OFF_AVEC};
  localparam logic [31:0] r_set = {24'h0, `UIA_OFF_SETUP};
  localparam logic [31:0] r_pwr = {24'h0, `UIA_OFF_PWR};
  logic clk_sys = 0;
  logic reset = 1;
  logic hsel = 0;
  logic hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, usb_events = 0, hrdata, rd;
  logic [31:0] hrdata_fs, rd_fs;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, setup_token_seen = 0, bus_activity = 0;
  logic [1:0] wake_pins = 0;
  uia_setup_wr_t setup_wr = '0;
  uia_fetch_t fetch;
  logic [15:0] pc = 0, edge_count;
  logic [7:0] fetch_byte_q;
  logic usb_int_q, usb_int_pulse_q, resume_irq_q, osc_run_q;
  int err_count = 0;
  int check_count = 0;
  always #2 clk_sys = ~clk_sys;
  uia_top #(.FS_ONLY(1'b0), .NWAKE(2)) DUT (.clk_sys(clk_sys),
    .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .usb_events(usb_events), .setup_token_seen(setup_token_seen),
    .setup_wr(setup_wr), .wake_pins(wake_pins),
    .bus_activity(bus_activity), .fetch(fetch),
    .fetch_byte_q(fetch_byte_q), .usb_int_q(usb_int_q),
    .usb_int_pulse_q(usb_int_pulse_q), .resume_irq_q(resume_irq_q),
    .osc_run_q(osc_run_q));
  // full-speed-only build on the same bus, to see the dropped slots
  uia_top #(.FS_ONLY(1'b1), .NWAKE(2)) DUT_FS (.clk_sys(clk_sys),
    .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata_fs), .hreadyout(), .hresp(),
    .usb_events(usb_events), .setup_token_seen(setup_token_seen),
    .setup_wr(setup_wr), .wake_pins(wake_pins),
    .bus_activity(bus_activity), .fetch(fetch), .fetch_byte_q(),
    .usb_int_q(), .usb_int_pulse_q(), .resume_irq_q(), .osc_run_q());
  uia_core_model core (.clk_sys(clk_sys), .reset(reset),
    .usb_int_pulse_q(usb_int_pulse_q), .pc(pc), .fetch(fetch),
    .edge_count(edge_count));
  task automatic final_report;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // address phase held until hready, data phase until hready again
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    rd_fs = hrdata_fs;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic ev(input logic [31:0] m);
    @(posedge clk_sys);
    usb_events <= m;
    @(posedge clk_sys);
    usb_events <= 32'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic fetch_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    pc <= a;
    repeat (2) @(posedge clk_sys);
    chk({24'h0, fetch_byte_q}, {24'h0, e});
  endtask
  task automatic t_reset;
    rd_chk(r_irq, 32'h0);
    rd_chk(r_av, 32'h0);
    rd_chk(32'h0000_001c, 32'h0);
    chk({31'h0, osc_run_q}, 32'h1);
  endtask
  task automatic t_priority;
    logic [15:0] n;
    wr(r_ie, 32'hffff_ffff);
    wr(r_en, 32'h1);
    n = edge_count;
    ev(32'h0000_1010);
    repeat (2) @(posedge clk_sys);
    chk({16'h0, edge_count}, {16'h0, n + 16'h1});
    rd_chk(r_av, 32'h10);
    rd_chk(r_main, 32'h10);
    chk({31'h0, usb_int_q}, 32'h1);
    wr(r_main, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, usb_int_q}, 32'h0);
    wr(r_irq, 32'h10);
    repeat (4) @(posedge clk_sys);
    chk({16'h0, edge_count}, {16'h0, n + 16'h2});
    rd_chk(r_av, 32'h30);
    wr(r_main, 32'h0);
    wr(r_irq, 32'h1000);
    n = edge_count;
    repeat (8) @(posedge clk_sys);
    chk({16'h0, edge_count}, {16'h0, n});
    rd_chk(r_av, 32'h30);
    // a masked source still latches but must not reach the core
    wr(r_ie, 32'hffff_fffd);
    ev(32'h2);
    chk({31'h0, usb_int_q}, 32'h0);
    wr(r_irq, 32'h0);
    rd_chk(r_irq, 32'h2);
    wr(r_irq, 32'h2);
    rd_chk(r_irq, 32'h0);
    wr(r_ie, 32'hffff_ffff);
  endtask
  task automatic t_vectors;
    logic [31:0] m;
    logic [31:0] drop;
    drop = `UIA_RSV_MASK | `UIA_HS_MASK;
    for (int i = 1; i < 32; i++) begin
      if (i != 2) begin
        m = 32'h1 << i;
        ev(m);
        rd_chk(r_irq, (m & `UIA_RSV_MASK) != 0 ? 32'h0 : m);
        chk(rd_fs, (m & drop) != 0 ? 32'h0 : m);
        if ((m & `UIA_RSV_MASK) == 0) begin
          rd_chk(r_av, 32'(i * 4));
        end
        wr(r_main, 32'h0);
        wr(r_irq, m);
      end
    end
  endtask
  task automatic t_fetch;
    wr(r_set, 32'h0);
    fetch_chk(16'h0045, 8'hba);
    wr(r_set, 32'h1);
    fetch_chk(16'h0045, 8'h7c);
    fetch_chk(16'h0044, 8'hbb);
    wr(r_set, 32'h0);
  endtask
  task automatic t_setup(input logic bad);
    @(posedge clk_sys);
    setup_token_seen <= 1'b1;
    @(posedge clk_sys);
    setup_token_seen <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      setup_wr <= '{we: 1'b1, idx: 3'(i), data: 8'(8'h30 + i),
        err: bad && i == 3};
    end
    @(posedge clk_sys);
    setup_wr <= '0;
    repeat (3) @(posedge clk_sys);
    rd_chk(r_irq, bad ? 32'h4 : 32'h5);
    for (int i = 0; i < 8 && !bad; i++) begin
      rd_chk({24'h0, `UIA_OFF_SDAT} + 32'(4 * i), 32'(8'h30 + i));
    end
    wr(r_main, 32'h0);
    wr(r_irq, 32'h5);
  endtask
  task automatic t_wake(input logic k);
    wr(r_pwr, 32'h2);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, osc_run_q}, 32'h0);
    wake_pins <= {1'b0, !k};
    bus_activity <= k;
    repeat (8) @(posedge clk_sys);
    chk({31'h0, osc_run_q}, 32'h1);
    chk({31'h0, resume_irq_q}, 32'h1);
    chk({31'h0, usb_int_q}, 32'h0);
    wake_pins <= 2'h0;
    bus_activity <= 1'b0;
    wr(r_pwr, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, resume_irq_q}, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_priority();
    t_vectors();
    t_fetch();
    t_setup(1'b0);
    t_setup(1'b1);
    t_wake(1'b0);
    t_wake(1'b1);
    final_report();
  end
  // whole run needs under a thousand cycles; this bound only cuts a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
